/* rtl/ssf_pkg.sv */
package ssf_pkg;
    // ****************************************
    // register map, byte address = word index times four
    // ****************************************
    localparam logic [3:0] OFS_S  = 4'h0;
    localparam logic [3:0] OFS_SA = 4'h4;
    localparam logic [3:0] OFS_SB = 4'h8;
    localparam logic [3:0] OFS_SC = 4'hC;
    localparam logic [3:0] OFS_EVT = 4'h0;

    // ****************************************
    // bit positions (reference number minus one)
    // ****************************************
    localparam int B_FIRST     = 0;
    localparam int B_LAST      = 1;
    localparam int B_T10MS     = 2;
    localparam int B_T100MS    = 3;
    localparam int B_T1S       = 4;
    localparam int B_T1MIN     = 5;
    localparam int B_ONE       = 6;
    localparam int B_ZERO      = 7;
    localparam int B_SYS_FULL  = 8;
    localparam int B_IO_FULL   = 9;
    localparam int B_OVR       = 10;
    localparam int B_BGCHK     = 12;
    localparam int B_BATBAD    = 13;
    localparam int B_HATT      = 16;
    localparam int B_HRD       = 17;
    localparam int B_HWR       = 18;
    localparam int B_RCMP      = 19;
    localparam int B_RUNSW     = 21;
    localparam int B_APPF      = 2;
    localparam int B_CFGMM     = 8;
    localparam int B_CPUHW     = 9;
    localparam int B_BATLOW    = 10;
    localparam int B_IOLOST    = 13;
    localparam int B_OPLOST    = 14;
    localparam int B_IOADD     = 18;
    localparam int B_OPADD     = 19;
    localparam int B_OPHW      = 26;
    localparam int B_OPSW      = 30;
    localparam int B_RAMBAD    = 9;
    localparam int B_PWD       = 10;
    localparam int B_CPUSW     = 12;
    localparam int B_STORE     = 13;
    localparam int B_ANY       = 8;
    localparam int B_SYSLOG    = 9;
    localparam int B_IOLOG     = 10;
    localparam int B_SYSPRES   = 11;
    localparam int B_IOPRES    = 12;
    localparam int B_HWSUM     = 13;
    localparam int B_SWSUM     = 14;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ       = 20_000_000;
    localparam int T10MS_HALF_US = 5_000;
    localparam int TICK_HALF_CYC = CLK_HZ / 1_000_000 * T10MS_HALF_US;
    localparam int DECADE        = 10;
    localparam int MIN_DIV       = 60;
endpackage

/* rtl/ssf_tick_if.sv */
`timescale 1ns/10ps
interface ssf_tick_if;
    logic [3:0] ticks;
    modport gen (output ticks);
    modport use_ (input ticks);
endinterface

/* rtl/ssf_tick_gen.sv */
`timescale 1ns/10ps
module ssf_tick_gen
    import ssf_pkg::*;
#(
    parameter int HALF_CYC = TICK_HALF_CYC
) (
    input  wire logic CLK,
    input  wire logic RST_B,
    ssf_tick_if.gen   tk
);
    // ****************************************
    // base 10 ms half-period prescaler, then two decades and a divide by 60
    // ****************************************
    logic [31:0] pre_q;
    logic [3:0]  d1_q;
    logic [3:0]  d2_q;
    logic [6:0]  d3_q;
    logic [3:0]  t_q;
    wire         pre_end = (pre_q == 32'(HALF_CYC - 1));
    wire         e1 = pre_end && (d1_q == 4'(DECADE - 1));
    wire         e2 = e1 && (d2_q == 4'(DECADE - 1));
    wire         e3 = e2 && (d3_q == 7'(MIN_DIV - 1));

    // toggling on half-period gives equal high and low time
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pre_q <= 32'h0;
            d1_q  <= 4'h0;
            d2_q  <= 4'h0;
            d3_q  <= 7'h00;
            t_q   <= 4'h0;
        end else begin
            pre_q <= pre_end ? 32'h0 : pre_q + 32'h1;
            if (pre_end) d1_q <= e1 ? 4'h0 : d1_q + 4'h1;
            if (e1) d2_q <= e2 ? 4'h0 : d2_q + 4'h1;
            if (e2) d3_q <= e3 ? 7'h00 : d3_q + 7'h01;
            t_q <= t_q ^ {e3, e2, e1, pre_end}; // RL3 RL23
        end
    end
    assign tk.ticks = t_q;
endmodule

/* rtl/ssf_bank.sv */
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// How it works
// RL1: first-sweep bit is one in the first sweep after start, zero after.
// RL2: last-sweep bit drops from one to zero in the final sweep.
// RL3: tick bits of 10 ms, 100 ms, 1 s and 1 min periods.
// RL4: writes to the read-only word are ignored.
// RL5: table-full bits follow full inputs, cleared on entry removal or clear; only the system-table bit is masked by the clear here.
// RL6: override bit and background-check bit follow their conditions.
// RL7: bad-battery bit refreshed once per sweep.
// RL8: three host bits for serial port one.
// RL9: real-compare bit set on success, cleared on not-a-number operand.
// RL10: run switch bit, one run, zero stop.
// RL11: the three fault words can be read and written by software.
// RL12: application fault set by event, cleared on stop-to-run.
// RL13: mismatch set at power-up or store, cleared at a clean power-up.
// RL14: processor hardware and low-battery bits set by their faults.
// RL15: module-lost bits set on lost communication, cleared by power cycle.
// RL16: module-added bits cleared by power cycle or matching store.
// RL17: option module hardware and software fault bits, cleared by power cycle.
// RL18: corrupt-memory bit set or cleared by power-up memory check.
// RL19: password and processor software bits cleared by system table clear.
// RL20: store-error bit set on failed store, cleared on good store.
// RL21: summary bits set on faults, cleared when both tables empty.
// RL22: per-table logged and present bits, cleared when table empty.
// RL23: ticks have equal high and low times.
// RL24: ticks only change between sweeps.
// RL25: constant one and constant zero bits.
module ssf_bank
    import ssf_pkg::*;
#(
    parameter int HALF_CYC = TICK_HALF_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    input  wire logic        SWEEP_END,
    input  wire logic        PROGRAM_STOPPING,
    input  wire logic        POWER_UP,
    input  wire logic        RUN_SWITCH,
    input  wire logic        SYS_TABLE_FULL,
    input  wire logic        IO_TABLE_FULL,
    input  wire logic        SYS_TABLE_CLEAR,
    input  wire logic        SYS_ENTRY_ADDED,
    input  wire logic        IO_ENTRY_ADDED,
    input  wire logic        SYS_TABLE_EMPTY,
    input  wire logic        IO_TABLE_EMPTY,
    input  wire logic        OVERRIDE_EXISTS,
    input  wire logic        BACKGROUND_CHECK,
    input  wire logic        BATTERY_BAD_IN,
    input  wire logic        HOST_ATTACHED,
    input  wire logic        HOST_READ,
    input  wire logic        HOST_WRITE,
    input  wire logic        REAL_CMP_OK,
    input  wire logic        REAL_CMP_NAN,
    input  wire logic        RUN_STARTED,
    input  wire logic        APP_FAULT_EV,
    input  wire logic        CFG_MISMATCH_EV,
    input  wire logic        STORE_DONE_OK,
    input  wire logic        STORE_FAILED_EV,
    input  wire logic        CPU_HW_EV,
    input  wire logic        BAT_LOW_EV,
    input  wire logic        IO_LOST_EV,
    input  wire logic        OPT_LOST_EV,
    input  wire logic        IO_ADDED_EV,
    input  wire logic        OPT_ADDED_EV,
    input  wire logic        OPT_HW_EV,
    input  wire logic        OPT_SW_EV,
    input  wire logic        RAM_BAD_EV,
    input  wire logic        PASSWORD_EV,
    input  wire logic        CPU_SW_EV,
    input  wire logic        HW_FAULT_EV,
    input  wire logic        SW_FAULT_EV,
    output logic [31:0]      STATUS_S
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NP = 36;
    // empty inputs idle high, so presence bits stay low while the flops fill
    localparam logic [NP-1:0] SYNC_IDLE = 36'h0_0600_0000;
    logic [NP-1:0] s1_q;
    logic [NP-1:0] s2_q;
    wire  [NP-1:0] pins = {SWEEP_END, PROGRAM_STOPPING, POWER_UP, RUN_SWITCH,
        SYS_TABLE_FULL, IO_TABLE_FULL, SYS_TABLE_CLEAR, SYS_ENTRY_ADDED,
        IO_ENTRY_ADDED, SYS_TABLE_EMPTY, IO_TABLE_EMPTY, OVERRIDE_EXISTS,
        BACKGROUND_CHECK, BATTERY_BAD_IN, HOST_ATTACHED, HOST_READ, HOST_WRITE,
        REAL_CMP_OK, REAL_CMP_NAN, RUN_STARTED, APP_FAULT_EV, CFG_MISMATCH_EV,
        STORE_DONE_OK, STORE_FAILED_EV, CPU_HW_EV, BAT_LOW_EV, IO_LOST_EV,
        OPT_LOST_EV, IO_ADDED_EV, OPT_ADDED_EV, OPT_HW_EV, OPT_SW_EV,
        RAM_BAD_EV, PASSWORD_EV, CPU_SW_EV, HW_FAULT_EV};
    logic sw_s1_q;
    logic sw_s2_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q    <= SYNC_IDLE;
            s2_q    <= SYNC_IDLE;
            sw_s1_q <= 1'b0;
            sw_s2_q <= 1'b0;
        end else begin
            s1_q    <= pins;
            s2_q    <= s1_q;
            sw_s1_q <= SW_FAULT_EV;
            sw_s2_q <= sw_s1_q;
        end
    end

    wire sweep   = s2_q[35];
    wire stop_s  = s2_q[34];
    wire pup     = s2_q[33];
    wire run_s   = s2_q[32];
    wire sfull   = s2_q[31];
    wire iofull  = s2_q[30];
    wire sclr    = s2_q[29];
    wire sadd    = s2_q[28];
    wire ioadd   = s2_q[27];
    wire sempty  = s2_q[26];
    wire ioempty = s2_q[25];
    wire ovr     = s2_q[24];
    wire bgc     = s2_q[23];
    wire batb    = s2_q[22];
    wire hatt    = s2_q[21];
    wire hrd     = s2_q[20];
    wire hwr     = s2_q[19];
    wire rok     = s2_q[18];
    wire rnan    = s2_q[17];
    wire runst   = s2_q[16];
    wire appf    = s2_q[15];
    wire cfgmm   = s2_q[14];
    wire stok    = s2_q[13];
    wire stfail  = s2_q[12];
    wire cpuhw   = s2_q[11];
    wire batlow  = s2_q[10];
    wire iolost  = s2_q[9];
    wire oplost  = s2_q[8];
    wire ioadded = s2_q[7];
    wire opadded = s2_q[6];
    wire ophw    = s2_q[5];
    wire opsw    = s2_q[4];
    wire rambad  = s2_q[3];
    wire pwd     = s2_q[2];
    wire cpusw   = s2_q[1];
    wire hwev    = s2_q[0];
    wire swev    = sw_s2_q;

    // ****************************************
    // sticky flag helper: set wins over clear
    // ****************************************
    function automatic logic flag(input logic cur, input logic set, input logic clr,
                                  input logic wen, input logic wval);
        logic v;
        v = wen ? wval : cur;
        if (clr) v = 1'b0;
        if (set) v = 1'b1;
        return v;
    endfunction

    // ****************************************
    // tick source and sweep sampling
    // ****************************************
    ssf_tick_if tk ();
    ssf_tick_gen #(.HALF_CYC(HALF_CYC)) u_tick (
        .CLK   (CLK),
        .RST_B (RST_B),
        .tk    (tk.gen)
    );

    logic [3:0] tick_q;
    logic       first_sweep_flag_q;
    logic       last_sweep_flag_q;
    logic       seen_sweep_q;
    logic       battery_bad_q;
    logic       rcmp_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_q             <= 4'h0;
            first_sweep_flag_q <= 1'b1;
            last_sweep_flag_q  <= 1'b1;
            seen_sweep_q       <= 1'b0;
            battery_bad_q      <= 1'b0;
            rcmp_q             <= 1'b0;
        end else begin
            if (sweep) begin
                tick_q             <= tk.ticks;   // RL24
                first_sweep_flag_q <= 1'b0;       // RL1
                battery_bad_q      <= batb;       // RL7
                seen_sweep_q       <= 1'b1;
            end
            if (pup) first_sweep_flag_q <= 1'b1;  // RL1
            last_sweep_flag_q <= !stop_s;         // RL2
            if (rnan) rcmp_q <= 1'b0;             // RL9
            if (rok) rcmp_q <= 1'b1;              // RL9
        end
    end

    logic [31:0] s_word;
    always_comb begin
        s_word            = RST_WORD;
        s_word[B_FIRST]   = first_sweep_flag_q;
        s_word[B_LAST]    = last_sweep_flag_q;
        s_word[B_T10MS]   = tick_q[0];         // RL3
        s_word[B_T100MS]  = tick_q[1];
        s_word[B_T1S]     = tick_q[2];
        s_word[B_T1MIN]   = tick_q[3];
        s_word[B_ONE]     = 1'b1;              // RL25
        s_word[B_ZERO]    = 1'b0;              // RL25
        s_word[B_SYS_FULL] = sfull && !sclr;   // RL5
        s_word[B_IO_FULL] = iofull;            // RL5
        s_word[B_OVR]     = ovr;               // RL6
        s_word[B_BGCHK]   = bgc;               // RL6
        s_word[B_BATBAD]  = battery_bad_q;
        s_word[B_HATT]    = hatt;              // RL8
        s_word[B_HRD]     = hrd;               // RL8
        s_word[B_HWR]     = hwr;               // RL8
        s_word[B_RCMP]    = rcmp_q;
        s_word[B_RUNSW]   = run_s;             // RL10
    end
    assign STATUS_S = s_word;

    // ****************************************
    // writable fault words
    // ****************************************
    wire w_sa = WR && (ADDR == OFS_SA);   // RL4 RL11
    wire w_sb = WR && (ADDR == OFS_SB);
    wire w_sc = WR && (ADDR == OFS_SC);
    // the read-only word has no write decode at all
    wire both_empty = sempty && ioempty;

    logic [31:0] sa_q;
    logic [31:0] sb_q;
    logic [31:0] sc_q;
    logic [31:0] sa_d;
    logic [31:0] sb_d;
    logic [31:0] sc_d;

    always_comb begin
        sa_d = w_sa ? WDATA : sa_q;
        sa_d[B_APPF]   = flag(sa_q[B_APPF], appf, runst, w_sa, WDATA[B_APPF]);      // RL12
        sa_d[B_CFGMM]  = flag(sa_q[B_CFGMM], cfgmm, pup, w_sa, WDATA[B_CFGMM]);     // RL13
        sa_d[B_CPUHW]  = flag(sa_q[B_CPUHW], cpuhw, 1'b0, w_sa, WDATA[B_CPUHW]);    // RL14
        sa_d[B_BATLOW] = flag(sa_q[B_BATLOW], batlow, pup, w_sa, WDATA[B_BATLOW]);  // RL14
        sa_d[B_IOLOST] = flag(sa_q[B_IOLOST], iolost, pup, w_sa, WDATA[B_IOLOST]);  // RL15
        sa_d[B_OPLOST] = flag(sa_q[B_OPLOST], oplost, pup, w_sa, WDATA[B_OPLOST]);  // RL15
        sa_d[B_IOADD]  = flag(sa_q[B_IOADD], ioadded, pup || stok, w_sa, WDATA[B_IOADD]); // RL16
        sa_d[B_OPADD]  = flag(sa_q[B_OPADD], opadded, pup || stok, w_sa, WDATA[B_OPADD]); // RL16
        sa_d[B_OPHW]   = flag(sa_q[B_OPHW], ophw, pup, w_sa, WDATA[B_OPHW]);        // RL17
        sa_d[B_OPSW]   = flag(sa_q[B_OPSW], opsw, pup, w_sa, WDATA[B_OPSW]);        // RL17
        sb_d = w_sb ? WDATA : sb_q;
        // memory check result only applies at power-up
        sb_d[B_RAMBAD] = pup ? rambad : sb_d[B_RAMBAD];                              // RL18
        sb_d[B_PWD]    = flag(sb_q[B_PWD], pwd, sclr, w_sb, WDATA[B_PWD]);           // RL19
        sb_d[B_CPUSW]  = flag(sb_q[B_CPUSW], cpusw, sclr, w_sb, WDATA[B_CPUSW]);     // RL19
        sb_d[B_STORE]  = flag(sb_q[B_STORE], stfail, stok, w_sb, WDATA[B_STORE]);    // RL20
        sc_d = w_sc ? WDATA : sc_q;
        sc_d[B_ANY]    = flag(sc_q[B_ANY], sadd || ioadd || hwev || swev, both_empty,
                              w_sc, WDATA[B_ANY]);                                   // RL21
        sc_d[B_HWSUM]  = flag(sc_q[B_HWSUM], hwev, both_empty, w_sc, WDATA[B_HWSUM]); // RL21
        sc_d[B_SWSUM]  = flag(sc_q[B_SWSUM], swev, both_empty, w_sc, WDATA[B_SWSUM]); // RL21
        sc_d[B_SYSLOG] = flag(sc_q[B_SYSLOG], sadd, sempty, w_sc, WDATA[B_SYSLOG]);  // RL22
        sc_d[B_IOLOG]  = flag(sc_q[B_IOLOG], ioadd, ioempty, w_sc, WDATA[B_IOLOG]);  // RL22
        sc_d[B_SYSPRES] = !sempty;                                                   // RL22
        sc_d[B_IOPRES]  = !ioempty;                                                  // RL22
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sa_q <= RST_WORD;
            sb_q <= RST_WORD;
            sc_q <= RST_WORD;
        end else begin
            sa_q <= sa_d;
            sb_q <= sb_d;
            sc_q <= sc_d;
        end
    end

    // ****************************************
    // read port, data one cycle after strobe
    // ****************************************
    wire [31:0] rd_mux = (ADDR == OFS_S)  ? s_word :
                         (ADDR == OFS_SA) ? sa_q :
                         (ADDR == OFS_SB) ? sb_q :
                         (ADDR == OFS_SC) ? sc_q : 32'h0000_0000;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) RDATA <= 32'h0000_0000;
        else        RDATA <= RD ? rd_mux : 32'h0000_0000;
    end

    // ****************************************
    // checks
    // ****************************************
    a_ro_write: assert property (@(posedge CLK) disable iff (!RST_B)  // RL4
        WR && ADDR == OFS_S && !appf && !runst |=> sa_q[B_APPF] == $past(sa_q[B_APPF]))
        else $error("read-only write disturbed state");
    a_const_bits: assert property (@(posedge CLK) disable iff (!RST_B)  // RL25
        s_word[B_ONE] && !s_word[B_ZERO]) else $error("constant bits wrong");
    a_tick_stable: assert property (@(posedge CLK) disable iff (!RST_B)  // RL24
        !$past(sweep) |-> $stable(tick_q)) else $error("tick moved mid sweep");
    a_first_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL1
        sweep && !pup |=> !first_sweep_flag_q) else $error("first sweep stuck");
    a_bat_sweep: assert property (@(posedge CLK) disable iff (!RST_B)  // RL7
        !sweep |=> $stable(battery_bad_q)) else $error("battery bit moved");
    a_appf_set: assert property (@(posedge CLK) disable iff (!RST_B)  // RL12
        appf |=> sa_q[B_APPF]) else $error("app fault not set");
    a_pres_follow: assert property (@(posedge CLK) disable iff (!RST_B)  // RL22
        !sempty |=> sc_q[B_SYSPRES]) else $error("presence bit wrong");
    a_any_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL21
        both_empty && !sadd && !ioadd && !hwev && !swev |=> !sc_q[B_ANY])
        else $error("any-fault not cleared");
    a_store_ok: assert property (@(posedge CLK) disable iff (!RST_B)  // RL20
        stok && !stfail |=> !sb_q[B_STORE]) else $error("store bit not cleared");
    a_rcmp_nan: assert property (@(posedge CLK) disable iff (!RST_B)  // RL9
        rnan && !rok |=> !rcmp_q) else $error("real compare not cleared");
    a_first_set: assert property (@(posedge CLK) disable iff (!RST_B)  // RL1
        pup |=> first_sweep_flag_q) else $error("first sweep not rearmed");
    a_last_follow: assert property (@(posedge CLK) disable iff (!RST_B)  // RL2
        stop_s |=> !last_sweep_flag_q) else $error("last sweep bit not dropped");
    a_cfg_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL13
        pup && !cfgmm |=> !sa_q[B_CFGMM]) else $error("mismatch bit not cleared");
    a_cpuhw_set: assert property (@(posedge CLK) disable iff (!RST_B)  // RL14
        cpuhw |=> sa_q[B_CPUHW]) else $error("processor fault not set");
    a_lost_set: assert property (@(posedge CLK) disable iff (!RST_B)  // RL15
        iolost |=> sa_q[B_IOLOST]) else $error("module lost not set");
    a_added_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL16
        stok && !ioadded |=> !sa_q[B_IOADD]) else $error("module added not cleared");
    a_opt_set: assert property (@(posedge CLK) disable iff (!RST_B)  // RL17
        opsw |=> sa_q[B_OPSW]) else $error("option software fault not set");
    a_ram_check: assert property (@(posedge CLK) disable iff (!RST_B)  // RL18
        pup |=> sb_q[B_RAMBAD] == $past(rambad)) else $error("memory check bit wrong");
    a_pwd_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL19
        sclr && !pwd |=> !sb_q[B_PWD]) else $error("password bit not cleared");
    a_log_clear: assert property (@(posedge CLK) disable iff (!RST_B)  // RL22
        sempty && !sadd |=> !sc_q[B_SYSLOG]) else $error("logged bit not cleared");
    c_sweep:  cover property (@(posedge CLK) disable iff (!RST_B) sweep ##1 sweep);
    c_appf:   cover property (@(posedge CLK) disable iff (!RST_B) appf ##[1:5] runst);
    c_wr_sc:  cover property (@(posedge CLK) disable iff (!RST_B) w_sc);
    c_ram:    cover property (@(posedge CLK) disable iff (!RST_B) pup && rambad);
endmodule

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench
    import ssf_pkg::*;
;
    // ****************************************
    // stimulus and bookkeeping
    // ****************************************
    localparam int HC = 5;
    logic        clk, rst_b, wr, rd, sweep, sys_empty, io_empty;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, status_s, d, s0;
    logic [9:0]  lv;
    logic [18:0] ev;
    logic [4:0]  cl;
    logic [3:0]  fa;
    int          fails, samples_checked;
    // level input index -> status bit; the last one is inverted
    int lbit[9] = '{B_SYS_FULL, B_IO_FULL, B_OVR, B_BGCHK, B_HATT, B_HRD, B_HWR, B_RUNSW, B_LAST};
    // event index -> word, bit, clearing cause (0-4 pulse, 5 tables empty, 6 write)
    logic [3:0] ew[19] = '{OFS_SA, OFS_SA, OFS_SA, OFS_SA, OFS_SA, OFS_SA, OFS_SA, OFS_SA, OFS_SA,
                           OFS_SA, OFS_SB, OFS_SB, OFS_SB, OFS_SB, OFS_SC, OFS_SC, OFS_S, OFS_SC,
                           OFS_SC};
    int eb[19] = '{B_APPF, B_CFGMM, B_CPUHW, B_BATLOW, B_IOLOST, B_OPLOST, B_IOADD, B_OPADD,
                   B_OPHW, B_OPSW, B_RAMBAD, B_PWD, B_CPUSW, B_STORE, B_HWSUM, B_SWSUM, B_RCMP,
                   B_SYSLOG, B_IOLOG};
    int ec[19] = '{1, 0, 6, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 3, 5, 5, 4, 5, 5};

    ssf_bank #(.HALF_CYC(HC)) i_dut (
        .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SWEEP_END(sweep), .PROGRAM_STOPPING(lv[8]), .POWER_UP(cl[0]), .RUN_SWITCH(lv[7]),
        .SYS_TABLE_FULL(lv[0]), .IO_TABLE_FULL(lv[1]), .SYS_TABLE_CLEAR(cl[2]),
        .SYS_ENTRY_ADDED(ev[17]), .IO_ENTRY_ADDED(ev[18]), .SYS_TABLE_EMPTY(sys_empty),
        .IO_TABLE_EMPTY(io_empty), .OVERRIDE_EXISTS(lv[2]), .BACKGROUND_CHECK(lv[3]),
        .BATTERY_BAD_IN(lv[9]), .HOST_ATTACHED(lv[4]), .HOST_READ(lv[5]), .HOST_WRITE(lv[6]),
        .REAL_CMP_OK(ev[16]), .REAL_CMP_NAN(cl[4]), .RUN_STARTED(cl[1]), .APP_FAULT_EV(ev[0]),
        .CFG_MISMATCH_EV(ev[1]), .STORE_DONE_OK(cl[3]), .STORE_FAILED_EV(ev[13]),
        .CPU_HW_EV(ev[2]), .BAT_LOW_EV(ev[3]), .IO_LOST_EV(ev[4]), .OPT_LOST_EV(ev[5]),
        .IO_ADDED_EV(ev[6]), .OPT_ADDED_EV(ev[7]), .OPT_HW_EV(ev[8]), .OPT_SW_EV(ev[9]),
        .RAM_BAD_EV(ev[10]), .PASSWORD_EV(ev[11]), .CPU_SW_EV(ev[12]), .HW_FAULT_EV(ev[14]),
        .SW_FAULT_EV(ev[15]), .STATUS_S(status_s)
    );

    always #25 clk = ~clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cb(input logic [31:0] w, input int b, input logic e);
        chk({31'h0, w[b]}, {31'h0, e});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_word(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so take it there
    task automatic rd_word(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    // inputs pass a two-flop synchroniser, so allow settling before looking
    task automatic pulse(input int k, input logic is_ev);
        @(posedge clk);
        if (is_ev) ev[k] <= 1'b1;
        else cl[k] <= 1'b1;
        // memory is only checked at power-up, so its event rides on one
        if (is_ev && k == 10) cl[0] <= 1'b1;
        @(posedge clk);
        ev <= '0;
        cl <= '0;
        cyc(4);
    endtask

    task automatic meas(input int b, input int half, input int n);
        int   c;
        logic v;
        c = 0;
        v = status_s[b];
        while (status_s[b] === v && c < 70000) begin @(posedge clk); #1 c++; end
        repeat (n) begin
            v = status_s[b];
            c = 0;
            while (status_s[b] === v && c < 70000) begin @(posedge clk); #1 c++; end
            chk(32'(c), 32'(half));
        end
    endtask

    function automatic logic [31:0] expw(input logic [3:0] a, input logic [31:0] v);
        logic [31:0] m;
        m = (a == OFS_SA) ? 32'h440C_6704 : (a == OFS_SB) ? 32'h0000_3600 : 32'h0000_6700;
        return (v & m) | ((a == OFS_SC) ? 32'h0000_1800 : 32'h0);
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        cyc(90000);
        fails++;
        stop_test;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 1'b0; rst_b = 1'b0; wr = 1'b0; rd = 1'b0; sweep = 1'b0; addr = 4'h0;
        wdata = 32'h0; lv = '0; ev = '0; cl = '0; sys_empty = 1'b1; io_empty = 1'b1;
        fails = 0;
        samples_checked = 0;
        void'($urandom(32'h1D13));
        cyc(5);
        rst_b <= 1'b1;
        cyc(4);
        rd_word(OFS_S, d);
        cb(d, B_FIRST, 1'b1);
        cb(d, B_ONE, 1'b1);
        cb(d, B_ZERO, 1'b0);
        rd_word(OFS_SC, d);
        chk(d, 32'h0);
        rd_word(4'h2, d);
        chk(d, 32'h0);
        pulse(0, 1'b0);
        sweep <= 1'b1;
        cyc(2);
        sweep <= 1'b0;
        cyc(5);
        #1 cb(status_s, B_FIRST, 1'b0);
        $display("test reset and first sweep done");
        for (int r = 0; r < 8; r++) begin
            @(posedge clk);
            lv[8:0] <= 9'($urandom);
            cyc(5);
            #1;
            for (int j = 0; j < 9; j++)
                cb(status_s, lbit[j], lv[j] ^ (j == 8));
        end
        @(posedge clk);
        lv[9] <= 1'b1;
        cyc(8);
        #1 cb(status_s, B_BATBAD, 1'b0);
        pulse(0, 1'b1);
        sweep <= 1'b1;
        cyc(1);
        sweep <= 1'b0;
        cyc(5);
        #1 cb(status_s, B_BATBAD, 1'b1);
        $display("test level mirrors done");
        rd_word(OFS_S, s0);
        wr_word(OFS_S, 32'hFFFF_FFFF);
        rd_word(OFS_S, d);
        chk(d, s0);
        chk(status_s, s0);
        $display("test read-only word done");
        @(posedge clk);
        sys_empty <= 1'b0;
        io_empty  <= 1'b0;
        for (int i = 0; i < 19; i++) begin
            pulse(i, 1'b1);
            rd_word(ew[i], d);
            cb(d, eb[i], 1'b1);
            if (ew[i] == OFS_SC) cb(d, B_ANY, 1'b1);
            if (ec[i] == 6) wr_word(ew[i], 32'h0);
            else if (ec[i] < 5) pulse(ec[i], 1'b0);
            else begin
                @(posedge clk);
                sys_empty <= 1'b1;
                io_empty  <= 1'b1;
                cyc(5);
            end
            rd_word(ew[i], d);
            cb(d, eb[i], 1'b0);
            if (ec[i] == 5) begin
                cb(d, B_ANY, 1'b0);
                cb(d, B_SYSPRES, 1'b0);
                @(posedge clk);
                sys_empty <= 1'b0;
                io_empty  <= 1'b0;
                cyc(5);
            end
        end
        $display("test fault events done");
        for (int r = 0; r < 9; r++) begin
            s0 = $urandom;
            fa = (r % 3 == 0) ? OFS_SA : (r % 3 == 1) ? OFS_SB : OFS_SC;
            wr_word(fa, expw(fa, s0));
            rd_word(fa, d);
            chk(d, expw(fa, s0));
            wr_word(fa, 32'h0);
        end
        $display("test fault word writes done");
        @(posedge clk);
        sweep <= 1'b1;
        cyc(4);
        for (int t = 0; t < 3; t++) meas(B_T10MS + t, HC * (10 ** t), 2);
        // half a minute, the half period of the 1 min tick, is 6000 half periods of the 10 ms tick
        meas(B_T1MIN, HC * 100 * MIN_DIV, 1);
        @(posedge clk);
        sweep <= 1'b0;
        cyc(4);
        s0 = status_s;
        cyc(3 * HC);
        #1 chk(status_s & 32'h3C, s0 & 32'h3C);
        $display("test tick contacts done");
        stop_test;
    end
endmodule
